// *** logic/dic_pkg.sv ***
// Constants, field layouts and carrier types of the digital input conditioning block
package dic_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DIC_DW = 32;
  localparam int DIC_IW = 8;
  localparam int DIC_SPECIAL_LO = 0;
  localparam int DIC_SPECIAL_HI = 15;
  localparam int DIC_PLAIN_LO = 16;
  localparam int DIC_PLAIN_HI = 31;
  localparam int DIC_SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // Sub-index map
  // ---------------------------------------------------------------
  localparam logic [7:0] DIC_IDX_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] DIC_IDX_FUNCTION_GATE = 8'h01;
  localparam logic [7:0] DIC_IDX_POLARITY_SELECT = 8'h02;
  localparam logic [7:0] DIC_IDX_OVERRIDE_ENABLE = 8'h03;
  localparam logic [7:0] DIC_IDX_OVERRIDE_VALUE = 8'h04;
  localparam logic [7:0] DIC_IDX_UNFILTERED_LEVEL = 8'h05;
  localparam logic [7:0] DIC_IDX_LEVEL_RANGE = 8'h06;
  localparam logic [7:0] DIC_IDX_PAIR_SELECT = 8'h07;
  localparam logic [7:0] DIC_IDX_REMAP_ENABLE = 8'h08;
  localparam logic [7:0] DIC_IDX_LAST = 8'h08;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] DIC_ENTRY_COUNT_VAL = 8'h08;
  localparam logic [31:0] DIC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DIC_SPECIAL_MASK = 32'h0000_FFFF;

  // ---------------------------------------------------------------
  // Special function bit positions
  // ---------------------------------------------------------------
  localparam int DIC_BIT_NEG_LIMIT = 0;
  localparam int DIC_BIT_POS_LIMIT = 1;
  localparam int DIC_BIT_HOME = 2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } dic_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dic_rsp_t;

  typedef struct packed {
    logic neg_limit;
    logic pos_limit;
    logic home;
  } dic_switch_t;

endpackage

// *** logic/dic_input_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module dic_input_sync #(
  parameter int W = 32
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] agree;

  // Stages two and three must match before a level is taken
  assign agree = ~(s2_r ^ s3_r);

  // Shift chain, first stage read only by the second
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted level per bit
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_r <= '0;
    end else if (ce_i) begin
      level_r <= (agree & s3_r) | (~agree & level_r);
    end
  end

  assign level_o = level_r;

endmodule

// *** logic/dic_top.sv ***
// Digital input conditioning: configuration entries, per-input conditioning and status word
`timescale 1ns/1ps
module dic_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] clkdir_sel_i,
  input wire dic_pkg::dic_req_t reg_req_i,
  output dic_pkg::dic_rsp_t reg_rsp_o,
  output logic [31:0] di_status_o,
  output dic_pkg::dic_switch_t switch_o,
  output logic di_change_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Synchronised pin levels
  logic [31:0] raw_level;

  // Configuration words and their next values
  logic [31:0] gate_r;
  logic [31:0] gate_nxt;
  logic [31:0] polarity_r;
  logic [31:0] polarity_nxt;
  logic [31:0] ovr_en_r;
  logic [31:0] ovr_en_nxt;
  logic [31:0] ovr_val_r;
  logic [31:0] ovr_val_nxt;
  logic [31:0] range_r;
  logic [31:0] range_nxt;
  logic [31:0] pair_r;
  logic [31:0] pair_nxt;
  logic [31:0] remap_r;
  logic [31:0] remap_nxt;

  // Conditioning chain
  logic [31:0] selected;
  logic [31:0] oriented;
  logic [31:0] conditioned;
  logic [31:0] invert_eff;

  // Status, switch and change registers
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  dic_pkg::dic_switch_t switch_r;
  dic_pkg::dic_switch_t switch_nxt;
  logic change_r;
  logic change_nxt;

  // Response path
  dic_pkg::dic_rsp_t rsp_r;
  dic_pkg::dic_rsp_t rsp_nxt;
  logic [31:0] rd_word;

  // Access decode
  logic wr_ok;
  logic rd_ok;
  logic bad_access;
  logic wr_gate;
  logic wr_polarity;
  logic wr_ovr_en;
  logic wr_ovr_val;
  logic wr_range;
  logic wr_pair;
  logic wr_remap;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // Sub-index exists in the entry table
  function automatic logic dic_idx_mapped(input logic [7:0] idx);
    dic_idx_mapped = (idx <= dic_pkg::DIC_IDX_LAST);
  endfunction

  // Sub-index accepts a stored write
  function automatic logic dic_idx_hit(input logic [7:0] idx, input logic [7:0] target);
    dic_idx_hit = (idx == target);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------

  // Raw pin levels enter the clock domain here
  dic_input_sync #(
    .W(dic_pkg::DIC_DW)
  ) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .pin_i(pin_i),
    .level_o(raw_level)
  );

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------

  // Entry count and raw word take no stored write
  assign wr_ok = reg_req_i.wr && dic_idx_mapped(reg_req_i.idx);
  assign rd_ok = reg_req_i.rd && dic_idx_mapped(reg_req_i.idx);
  assign bad_access = (reg_req_i.wr || reg_req_i.rd) && !dic_idx_mapped(reg_req_i.idx);

  // One write strobe per stored word
  assign wr_gate = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_FUNCTION_GATE);
  assign wr_polarity = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_POLARITY_SELECT);
  assign wr_ovr_en = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_OVERRIDE_ENABLE);
  assign wr_ovr_val = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_OVERRIDE_VALUE);
  assign wr_range = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_LEVEL_RANGE);
  assign wr_pair = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_PAIR_SELECT);
  assign wr_remap = wr_ok && dic_idx_hit(reg_req_i.idx, dic_pkg::DIC_IDX_REMAP_ENABLE);

  // Next values of the configuration words
  assign gate_nxt = wr_gate ? reg_req_i.wdata : gate_r;
  assign polarity_nxt = wr_polarity ? reg_req_i.wdata : polarity_r;
  assign ovr_en_nxt = wr_ovr_en ? reg_req_i.wdata : ovr_en_r;
  assign ovr_val_nxt = wr_ovr_val ? reg_req_i.wdata : ovr_val_r;
  assign range_nxt = wr_range ? reg_req_i.wdata : range_r;
  assign pair_nxt = wr_pair ? reg_req_i.wdata : pair_r;
  assign remap_nxt = wr_remap ? reg_req_i.wdata : remap_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  // Special function gate word, clear at reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      gate_r <= gate_nxt;
    end
  end

  // Polarity word, clear at reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      polarity_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      polarity_r <= polarity_nxt;
    end
  end

  // Override enable word, clear at reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovr_en_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      ovr_en_r <= ovr_en_nxt;
    end
  end

  // Override value word, clear at reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovr_val_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      ovr_val_r <= ovr_val_nxt;
    end
  end

  // Level range word, stored only
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      range_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      range_r <= range_nxt;
    end
  end

  // Pair select word, stored only
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pair_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      pair_r <= pair_nxt;
    end
  end

  // Remap enable word, stored only
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remap_r <= dic_pkg::DIC_CFG_RST;
    end else if (ce_i) begin
      remap_r <= remap_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Per-input conditioning
  // ---------------------------------------------------------------

  // Clock and direction inputs never invert
  assign invert_eff = polarity_r & ~clkdir_sel_i;

  // Override, polarity and gating per bit position
  for (genvar n = 0; n < dic_pkg::DIC_DW; n++) begin : g_cond
    // Software value replaces the pin when enabled
    assign selected[n] = ovr_en_r[n] ? ovr_val_r[n] : raw_level[n];
    // Normally closed logic turns a high level into 0
    assign oriented[n] = selected[n] ^ invert_eff[n];
    if (n <= dic_pkg::DIC_SPECIAL_HI) begin : g_special
      // Special function passes only while its gate is set
      assign conditioned[n] = oriented[n] & gate_r[n];
    end else begin : g_plain
      // Plain levels ignore the gate word
      assign conditioned[n] = oriented[n];
    end
  end

  // Status word built from the conditioned chain
  assign status_nxt = conditioned;

  // Switch functions by fixed bit position
  assign switch_nxt.neg_limit = conditioned[dic_pkg::DIC_BIT_NEG_LIMIT];
  assign switch_nxt.pos_limit = conditioned[dic_pkg::DIC_BIT_POS_LIMIT];
  assign switch_nxt.home = conditioned[dic_pkg::DIC_BIT_HOME];

  // Pulse when any status bit moves
  assign change_nxt = (status_nxt != status_r);

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------

  // Combined status word
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_r <= '0;
    end else if (ce_i) begin
      status_r <= status_nxt;
    end
  end

  // Limit and home switch outputs
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      switch_r <= '0;
    end else if (ce_i) begin
      switch_r <= switch_nxt;
    end
  end

  // One-cycle change pulse
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      change_r <= 1'b0;
    end else if (ce_i) begin
      change_r <= change_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Read mux over the entry table
  always_comb begin
    rd_word = '0;
    if (reg_req_i.idx == dic_pkg::DIC_IDX_ENTRY_COUNT) begin
      rd_word = {24'h00_0000, dic_pkg::DIC_ENTRY_COUNT_VAL};
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_FUNCTION_GATE) begin
      rd_word = gate_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_POLARITY_SELECT) begin
      rd_word = polarity_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_OVERRIDE_ENABLE) begin
      rd_word = ovr_en_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_OVERRIDE_VALUE) begin
      rd_word = ovr_val_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_UNFILTERED_LEVEL) begin
      rd_word = raw_level;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_LEVEL_RANGE) begin
      rd_word = range_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_PAIR_SELECT) begin
      rd_word = pair_r;
    end else if (reg_req_i.idx == dic_pkg::DIC_IDX_REMAP_ENABLE) begin
      rd_word = remap_r;
    end
  end

  // Answer one cycle after the request
  assign rsp_nxt.ack = wr_ok || rd_ok;
  assign rsp_nxt.err = bad_access;
  assign rsp_nxt.rdata = rd_ok ? rd_word : '0;

  // Response register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_r <= '0;
    end else if (ce_i) begin
      rsp_r <= rsp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every port comes straight from a register
  assign reg_rsp_o = rsp_r;
  assign di_status_o = status_r;
  assign switch_o = switch_r;
  assign di_change_o = change_r;

endmodule

// *** dv/dic_top_properties.sv ***
// Port-level assertions of the digital input conditioning top
`timescale 1ns/1ps
module dic_top_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] clkdir_sel_i,
  input wire dic_pkg::dic_req_t reg_req_i,
  input wire dic_pkg::dic_rsp_t reg_rsp_o,
  input wire logic [31:0] di_status_o,
  input wire dic_pkg::dic_switch_t switch_o,
  input wire logic di_change_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // --------------------------------
  // Helper terms
  // --------------------------------
  wire req_w = ce_i && (reg_req_i.wr || reg_req_i.rd);
  wire rd_w = req_w && reg_req_i.rd && !reg_req_i.wr;
  sequence pin_still_s;
    (ce_i && $stable(pin_i) && $stable(clkdir_sel_i))[*6];
  endsequence
  sequence quiet_s;
    (ce_i && !reg_req_i.wr && $stable(pin_i) && $stable(clkdir_sel_i))[*8];
  endsequence
  sequence wr_rd_s;
    req_w && reg_req_i.wr && !reg_req_i.rd && reg_req_i.idx == 8'h01 ##2
      rd_w && reg_req_i.idx == 8'h01;
  endsequence
  // --------------------------------
  // Assertions
  // --------------------------------
  err_idx_a: assert property (req_w && reg_req_i.idx > 8'h08 |=> reg_rsp_o.err)
    else $error("unmapped index not refused");
  ack_map_a: assert property (req_w && reg_req_i.idx <= 8'h08 |=> reg_rsp_o.ack)
    else $error("mapped access not acknowledged");
  count_read_a: assert property (rd_w && reg_req_i.idx == 8'h00 |=>
    reg_rsp_o.rdata == 32'h0000_0008) else $error("entry count wrong");
  write_back_a: assert property (wr_rd_s |=> reg_rsp_o.rdata == $past(reg_req_i.wdata, 3))
    else $error("gate word not stored");
  raw_read_a: assert property (pin_still_s ##0 rd_w && reg_req_i.idx == 8'h05 |=>
    reg_rsp_o.rdata == $past(pin_i)) else $error("raw word differs from pins");
  switch_map_a: assert property (switch_o.neg_limit == di_status_o[0] &&
    switch_o.pos_limit == di_status_o[1] && switch_o.home == di_status_o[2])
    else $error("switch bits differ from status");
  change_flag_a: assert property (di_change_o |-> di_status_o != $past(di_status_o))
    else $error("change pulse without change");
  change_pulse_a: assert property ($past(ce_i) && di_status_o != $past(di_status_o) |->
    di_change_o) else $error("status moved without change pulse");
  quiet_hold_a: assert property (quiet_s |-> $stable(di_status_o) && !di_change_o)
    else $error("status moved without cause");
  idle_quiet_a: assert property (!req_w |=> !reg_rsp_o.ack && !reg_rsp_o.err)
    else $error("response without request");
endmodule
bind dic_top dic_top_checker u_dic_top_checker (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .pin_i(pin_i), .clkdir_sel_i(clkdir_sel_i), .reg_req_i(reg_req_i),
  .reg_rsp_o(reg_rsp_o), .di_status_o(di_status_o), .switch_o(switch_o),
  .di_change_o(di_change_o));

// *** dv/dic_pin_model.sv ***
// Behavioural model of the input pins and switches facing the block
`timescale 1ns/1ps
module dic_pin_model (
  input wire logic mclk_i,
  input wire logic [31:0] level_i,
  input wire logic stray_i,
  output logic [31:0] pin_o
);
  logic [12:0] stray_r = 13'h0000;
  // Unwired special inputs 3-15 pick up a steady stray level
  always @(posedge mclk_i) stray_r <= stray_i ? 13'h1FFF : 13'h0000;
  // Switches and plain inputs follow the wanted levels
  assign pin_o = {level_i[31:16], level_i[15:3] ^ stray_r, level_i[2:0]};
endmodule

// *** dv/dic_top_tb.sv ***
// Self-checking testbench of the digital input conditioning top
`timescale 1ns/1ps
module dic_top_tb;
  logic mclk_i, resetn_i, ce_i, stray, chg;
  logic [31:0] lvl, cd, pin_w, st, gate, pol, fe, fv, held;
  dic_pkg::dic_req_t req;
  dic_pkg::dic_rsp_t rsp;
  dic_pkg::dic_switch_t sw;
  int miscompares = 0;
  int checked = 0;
  int k;
  dic_pin_model u_dic_pin_model (.mclk_i(mclk_i), .level_i(lvl), .stray_i(stray),
    .pin_o(pin_w));
  dic_top u_dic_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .pin_i(pin_w),
    .clkdir_sel_i(cd), .reg_req_i(req), .reg_rsp_o(rsp), .di_status_o(st),
    .switch_o(sw), .di_change_o(chg));
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One access; pulse taken at the next edge, answer seen just after it
  task automatic acc(input logic [7:0] i, input logic w, input logic [31:0] d,
    input logic e);
    int n;
    @(posedge mclk_i);
    req <= '{idx: i, wr: w, rd: !w, wdata: d};
    @(posedge mclk_i);
    req <= '0;
    #1;
    for (n = 0; n < 4 && rsp.ack !== 1'b1 && rsp.err !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    if (n == 4) begin
      miscompares++;
      test_done();
    end
    chk("err", {31'h0, e}, {31'h0, rsp.err});
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    acc(i, 1'b0, 32'h0, 1'b0);
    chk("rdata", e, rsp.rdata);
  endtask
  // Expected status from the pins and the configuration words
  function automatic logic [31:0] expv();
    logic [31:0] o;
    o = ((fe & fv) | (~fe & lvl)) ^ (pol & ~cd);
    return {o[31:16], o[15:0] & gate[15:0]};
  endfunction
  task automatic settle;
    logic [31:0] e;
    repeat (8) @(posedge mclk_i);
    #1;
    e = expv();
    chk("status", e, st);
    chk("switch", {29'h0, e[0], e[1], e[2]}, {29'h0, sw});
  endtask
  // --------------------------------
  // Clock and sequence
  // --------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    {resetn_i, stray, lvl, cd, gate, pol, fe, fv, held} = '0;
    ce_i = 1'b1;
    req = '0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rdc(8'h00, 32'h0000_0008);
    for (k = 1; k < 9; k++) rdc(k[7:0], 32'h0);
    acc(8'h09, 1'b0, 32'h0, 1'b1);
    $display("test reset done");
    @(posedge mclk_i);
    lvl <= 32'hA5A5_0007;
    settle();
    gate = 32'hFFFF_FFFF;
    acc(8'h01, 1'b1, gate, 1'b0);
    rdc(8'h01, gate);
    settle();
    $display("test gate done");
    pol = 32'h0003_0003;
    @(posedge mclk_i);
    cd <= 32'h0001_0000;
    acc(8'h02, 1'b1, pol, 1'b0);
    settle();
    fe = 32'h8000_0005;
    fv = 32'h0000_0004;
    acc(8'h03, 1'b1, fe, 1'b0);
    acc(8'h04, 1'b1, fv, 1'b0);
    settle();
    acc(8'h05, 1'b1, 32'h0, 1'b0);
    rdc(8'h05, lvl);
    $display("test override done");
    gate = 32'h0000_0007;
    acc(8'h01, 1'b1, gate, 1'b0);
    @(posedge mclk_i);
    stray <= 1'b1;
    settle();
    $display("test stray done");
    held = expv();
    @(posedge mclk_i);
    ce_i <= 1'b0;
    lvl <= 32'h5A5A_0002;
    repeat (8) @(posedge mclk_i);
    #1;
    chk("frozen", held, st);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    settle();
    $display("test enable done");
    test_done();
  end
endmodule
